// >>> fpc_defs.vh
/*
 * Shared constants of the flash command front end: opcodes, region sizes,
 * reset values. Assumes plain Verilog-2005 and inclusion by bare name.
 */
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH

// Opcodes handled by the front end
`define FPC_OP_WREN 8'h06
`define FPC_OP_WRDI 8'h04
`define FPC_OP_RDSR 8'h05
`define FPC_OP_READ 8'h03
`define FPC_OP_FREAD 8'h0b
`define FPC_OP_PGM 8'h02
`define FPC_OP_SE4K 8'h20
`define FPC_OP_BE32K 8'h52
`define FPC_OP_BE64K 8'hd8
`define FPC_OP_CE_A 8'hc7
`define FPC_OP_CE_B 8'h60
`define FPC_OP_ID8 8'hab
`define FPC_OP_MID 8'h90
`define FPC_OP_JID 8'h9f
`define FPC_OP_GLOCK 8'h7e
`define FPC_OP_GUNLOCK 8'h98
`define FPC_OP_BLOCK 8'h36
`define FPC_OP_BUNLOCK 8'h39
`define FPC_OP_QPI_ON 8'h38
`define FPC_OP_QPI_OFF 8'hff

// Region size masks (bytes minus one)
`define FPC_PAGE_MASK 24'h0000ff
`define FPC_SECT_MASK 24'h000fff
`define FPC_B32_MASK 24'h007fff
`define FPC_B64_MASK 24'h00ffff
`define FPC_CHIP_MASK 24'hffffff

// Size shifts of the range decode
`define FPC_SECTOR_SHIFT 5'h0c
`define FPC_BLOCK_SHIFT 5'h10

// Bytes of opcode plus address
`define FPC_ADDR_BYTES 4'h4
// Lock bits come up set, whole array protected
`define FPC_LOCK_RESET 1'b1

`endif

// >>> fpc_fifo.v
/*
 * Synchronous FIFO for program data bytes, parameterised width and depth.
 * Assumes one clock, active-low asynchronous reset, depth a power of two.
 */
`timescale 1ns/1ps
module fpc_fifo #(
    parameter W = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk, // Clock
    input wire rst_b, // Async reset, active low
    input wire in_valid, // Write request
    input wire [W-1:0] in_data, // Write data
    output wire in_ready, // Room for a word
    output wire out_valid, // Word available
    output wire [W-1:0] out_data, // Head word
    input wire out_ready // Drain side takes word
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] cnt_reg;
    wire do_wr;
    wire do_rd;

    // Full and empty straight from the occupancy count
    assign in_ready = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;

    // Storage has no reset; only the pointers and count matter
    always @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and count
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule

// >>> fpc_protect.v
/*
 * Protection decision for one erase or program region.
 * Assumes a combinational use; inputs are stable in the deciding cycle.
 */
`timescale 1ns/1ps
`include "fpc_defs.vh"
module fpc_protect #(
    parameter AW = 22,
    parameter NBLK = 64,
    parameter BW = 6
) (
    input wire protect_scheme_select, // 1: block locks, 0: range bits
    input wire protect_complement, // Invert the range decode
    input wire sector_granularity_select, // 4KB steps instead of 64KB
    input wire top_bottom_select, // 1: range counts from bottom
    input wire [2:0] range_bits, // Range bits 2..0
    input wire [NBLK-1:0] lock_bits, // Block lock bits
    input wire [AW-1:0] region_lo, // First byte of region
    input wire [AW-1:0] region_hi, // Last byte of region
    output wire hit // Region touches protected data
);
    reg [4:0] sz_shift;
    reg [AW:0] norm_size;
    reg [AW:0] prot_size;
    reg [AW:0] prot_lo;
    reg [AW:0] prot_hi;
    reg from_top;
    wire range_hit;
    wire [NBLK-1:0] blk_hit;
    wire [AW:0] full_size = {1'b1, {AW{1'b0}}};

    // Size of the normal range, then complement and pick a side
    always @* begin
        if (sector_granularity_select) begin
            sz_shift = `FPC_SECTOR_SHIFT + (range_bits[2] ? 5'h03 : {3'b000, range_bits[1:0]} - 5'h01);
        end else begin
            sz_shift = `FPC_BLOCK_SHIFT + {2'b00, range_bits} - 5'h01;
        end
        if (range_bits == 3'b000) begin
            norm_size = {(AW+1){1'b0}};
        end else if (range_bits == 3'b111) begin
            norm_size = full_size;
        end else begin
            norm_size = {{AW{1'b0}}, 1'b1} << sz_shift;
        end
        // Complement keeps the other end of the array
        prot_size = protect_complement ? full_size - norm_size : norm_size;
        from_top = ~(top_bottom_select ^ protect_complement);
        prot_lo = from_top ? full_size - prot_size : {(AW+1){1'b0}};
        prot_hi = from_top ? full_size - 1'b1 : prot_size - 1'b1;
    end

    // Any overlap with the protected interval counts
    assign range_hit = (prot_size != {(AW+1){1'b0}}) && ({1'b0, region_lo} <= prot_hi)
        && ({1'b0, region_hi} >= prot_lo);

    // One compare per block against the region's block span
    genvar g;
    generate
        for (g = 0; g < NBLK; g = g + 1) begin : blk
            localparam [BW-1:0] IDX = g;
            assign blk_hit[g] = lock_bits[g] && (region_lo[AW-1:AW-BW] <= IDX)
                && (region_hi[AW-1:AW-BW] >= IDX);
        end
    endgenerate

    assign hit = protect_scheme_select ? |blk_hit : range_hit;
endmodule

// >>> fpc_frontend.v
/*
 * Serial flash command front end: frames instructions from the host link,
 * answers status and identification reads, keeps the block locks and gates
 * erase and program requests against write protection.
 * Assumes a host-driven serial clock much slower than core_clk (at least
 * four core cycles per phase) and a same-clock array engine behind it.
 */
`timescale 1ns/1ps
`include "fpc_defs.vh"
module fpc_frontend #(
    parameter AW = 22,
    parameter NBLK = 64,
    parameter BW = 6,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4,
    parameter [7:0] MAKER_CODE = 8'ha5, // Arbitrary value
    parameter [7:0] DEV_CODE8 = 8'h3c, // Arbitrary value
    parameter [15:0] DEV_CODE16 = 16'h7e21 // Arbitrary value
) (
    input wire core_clk, // Core clock, 25 MHz
    input wire rst_b, // Async reset, active low
    input wire chip_sel_b, // Chip select pin, active low
    input wire serial_clk, // Host serial clock pin
    input wire [3:0] io_in, // Data pins in; bit 0 is serial_input_line
    output reg [3:0] io_out, // Data pins out
    output reg [3:0] io_oe, // Data pin drive enables
    input wire protect_scheme_select, // Lock scheme when high
    input wire protect_complement, // Invert range decode
    input wire sector_granularity_select, // Range in 4KB steps
    input wire top_bottom_select, // Range from bottom
    input wire range_bit_2, // Range bit 2
    input wire range_bit_1, // Range bit 1
    input wire range_bit_0, // Range bit 0
    input wire quad_enable_bit, // Quad lines allowed
    input wire [7:0] status_byte, // Status returned on status read
    input wire write_cycle_busy, // Array engine busy
    output reg four_wire_instruction_mode, // Four-wire mode active
    output reg op_go, // Pulse: start erase/program
    output reg [7:0] op_code, // Opcode of started operation
    output reg [23:0] op_addr, // Address of started operation
    output reg op_blocked, // Pulse: refused by protection
    output reg op_dropped, // Pulse: program/erase discarded
    output wire [7:0] pgm_data, // Program data byte
    output wire pgm_valid, // Program data available
    input wire pgm_ready, // Engine takes program byte
    output reg pgm_space, // FIFO can take a byte
    output reg pgm_overrun // Byte lost in this frame
);
    reg [2:0] cs_sync_reg;
    reg [2:0] sck_sync_reg;
    reg [3:0] io_s1_reg;
    reg [3:0] io_s2_reg;
    reg [2:0] bit_cnt_reg;
    reg [3:0] byte_cnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] opcode_reg;
    reg [23:0] addr_reg;
    reg [7:0] tx_reg;
    reg tx_on_reg;
    reg [NBLK-1:0] lock_reg;
    reg wr_valid_reg;
    reg [7:0] wr_data_reg;
    reg [8:0] resp;
    reg [23:0] mask;
    wire sel = ~cs_sync_reg[1];
    wire cs_fall = ~cs_sync_reg[1] & cs_sync_reg[2];
    wire cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
    wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
    wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
    wire quad = four_wire_instruction_mode;
    wire [7:0] rx_byte = quad ? {shift_reg[3:0], io_s2_reg} : {shift_reg[6:0], io_s2_reg[0]};
    wire [3:0] bit_sum = {1'b0, bit_cnt_reg} + (quad ? 4'h4 : 4'h1);
    wire byte_done = bit_sum[3];
    wire [3:0] byte_next = (byte_cnt_reg == 4'hf) ? 4'hf : byte_cnt_reg + 4'h1;
    wire [7:0] cur_op = (byte_cnt_reg == 4'h0) ? rx_byte : opcode_reg;
    wire is_pe = (opcode_reg == `FPC_OP_PGM) || (opcode_reg == `FPC_OP_SE4K)
        || (opcode_reg == `FPC_OP_BE32K) || (opcode_reg == `FPC_OP_BE64K)
        || (opcode_reg == `FPC_OP_CE_A) || (opcode_reg == `FPC_OP_CE_B);
    wire is_chip = (opcode_reg == `FPC_OP_CE_A) || (opcode_reg == `FPC_OP_CE_B);
    wire has_addr = is_chip || (byte_cnt_reg >= `FPC_ADDR_BYTES);
    wire aligned = (bit_cnt_reg == 3'h0);
    wire [AW-1:0] region_lo = addr_reg[AW-1:0] & ~mask[AW-1:0];
    wire [AW-1:0] region_hi = addr_reg[AW-1:0] | mask[AW-1:0];
    wire [BW-1:0] blk_idx = addr_reg[AW-1:AW-BW];
    wire prot_hit;
    wire fifo_in_ready;

    // Opcode sets of the two instruction modes
    function known_op;
        input [7:0] op;
        input q;
        begin
            case (op)
                `FPC_OP_WREN, `FPC_OP_WRDI, `FPC_OP_RDSR, `FPC_OP_PGM, `FPC_OP_SE4K,
                `FPC_OP_BE32K, `FPC_OP_BE64K, `FPC_OP_CE_A, `FPC_OP_CE_B, `FPC_OP_ID8,
                `FPC_OP_MID, `FPC_OP_JID, `FPC_OP_GLOCK, `FPC_OP_GUNLOCK, `FPC_OP_BLOCK,
                `FPC_OP_BUNLOCK, `FPC_OP_FREAD: known_op = 1'b1;
                `FPC_OP_READ, `FPC_OP_QPI_ON: known_op = ~q;
                `FPC_OP_QPI_OFF: known_op = q;
                default: known_op = 1'b0;
            endcase
        end
    endfunction

    // Reply byte for the byte slot about to be shifted out
    always @* begin
        resp = 9'h000;
        case (cur_op)
            `FPC_OP_RDSR: resp = {1'b1, status_byte};
            `FPC_OP_JID: begin
                if (byte_next == 4'h1) begin
                    resp = {1'b1, MAKER_CODE};
                end else if (byte_next == 4'h2) begin
                    resp = {1'b1, DEV_CODE16[15:8]};
                end else if (byte_next == 4'h3) begin
                    resp = {1'b1, DEV_CODE16[7:0]};
                end
            end
            `FPC_OP_MID: begin
                if (byte_next == 4'h4) begin
                    resp = {1'b1, MAKER_CODE};
                end else if (byte_next == 4'h5) begin
                    resp = {1'b1, DEV_CODE8};
                end
            end
            `FPC_OP_ID8: resp = {(byte_next >= 4'h4), DEV_CODE8};
            default: resp = 9'h000;
        endcase
        // Busy array answers only the status read
        if (write_cycle_busy && (cur_op != `FPC_OP_RDSR)) begin
            resp = 9'h000;
        end
        if (!known_op(cur_op, quad)) begin
            resp = 9'h000;
        end
    end

    // Region covered by the pending erase or program
    always @* begin
        case (opcode_reg)
            `FPC_OP_PGM: mask = `FPC_PAGE_MASK;
            `FPC_OP_SE4K: mask = `FPC_SECT_MASK;
            `FPC_OP_BE32K: mask = `FPC_B32_MASK;
            `FPC_OP_BE64K: mask = `FPC_B64_MASK;
            default: mask = `FPC_CHIP_MASK;
        endcase
    end

    fpc_protect #(.AW(AW), .NBLK(NBLK), .BW(BW)) u_protect (
        .protect_scheme_select(protect_scheme_select),
        .protect_complement(protect_complement),
        .sector_granularity_select(sector_granularity_select),
        .top_bottom_select(top_bottom_select),
        .range_bits({range_bit_2, range_bit_1, range_bit_0}),
        .lock_bits(lock_reg),
        .region_lo(region_lo),
        .region_hi(region_hi),
        .hit(prot_hit)
    );

    // Program bytes wait here until the engine drains them
    fpc_fifo #(.W(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_valid(wr_valid_reg),
        .in_data(wr_data_reg),
        .in_ready(fifo_in_ready),
        .out_valid(pgm_valid),
        .out_data(pgm_data),
        .out_ready(pgm_ready)
    );

    // Pin synchronisers; edge detect reads only the second stage onward
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_sync_reg <= 3'h7;
            sck_sync_reg <= 3'h0;
            io_s1_reg <= 4'h0;
            io_s2_reg <= 4'h0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[1:0], chip_sel_b};
            sck_sync_reg <= {sck_sync_reg[1:0], serial_clk};
            io_s1_reg <= io_in;
            io_s2_reg <= io_s1_reg;
        end
    end

    // Framing, replies, lock bits and execution at chip select rise
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            opcode_reg <= 8'h00;
            addr_reg <= 24'h000000;
            tx_reg <= 8'h00;
            tx_on_reg <= 1'b0;
            io_out <= 4'h0;
            io_oe <= 4'h0;
            lock_reg <= {NBLK{`FPC_LOCK_RESET}};
            four_wire_instruction_mode <= 1'b0;
            op_go <= 1'b0;
            op_code <= 8'h00;
            op_addr <= 24'h000000;
            op_blocked <= 1'b0;
            op_dropped <= 1'b0;
            wr_valid_reg <= 1'b0;
            wr_data_reg <= 8'h00;
            pgm_space <= 1'b1;
            pgm_overrun <= 1'b0;
        end else begin
            op_go <= 1'b0;
            op_blocked <= 1'b0;
            op_dropped <= 1'b0;
            wr_valid_reg <= 1'b0;
            pgm_space <= fifo_in_ready;
            if (cs_fall) begin
                // New frame: next byte in is the opcode
                bit_cnt_reg <= 3'h0;
                byte_cnt_reg <= 4'h0;
                shift_reg <= 8'h00;
                tx_on_reg <= 1'b0;
                pgm_overrun <= 1'b0;
            end else if (sel && sck_rise) begin
                // One bit or one nibble per rising edge, MSB first
                shift_reg <= rx_byte;
                bit_cnt_reg <= bit_sum[2:0];
                if (byte_done) begin
                    byte_cnt_reg <= byte_next;
                    if (byte_cnt_reg == 4'h0) begin
                        opcode_reg <= rx_byte;
                    end else if (byte_cnt_reg < `FPC_ADDR_BYTES) begin
                        addr_reg <= {addr_reg[15:0], rx_byte};
                    end else if ((opcode_reg == `FPC_OP_PGM) && !write_cycle_busy) begin
                        wr_valid_reg <= 1'b1;
                        wr_data_reg <= rx_byte;
                    end
                    tx_reg <= resp[7:0];
                    tx_on_reg <= resp[8];
                end
            end else if (sel && sck_fall && tx_on_reg) begin
                // Drive on falling edges so the host samples on the rise
                io_out <= quad ? tx_reg[7:4] : {2'b00, tx_reg[7], 1'b0};
                io_oe <= quad ? 4'hf : 4'h2;
                tx_reg <= quad ? {tx_reg[3:0], 4'h0} : {tx_reg[6:0], 1'b0};
            end
            if (wr_valid_reg && !fifo_in_ready) begin
                pgm_overrun <= 1'b1;
            end
            if (cs_rise) begin
                // Reads simply stop; nothing else happens for them
                io_oe <= 4'h0;
                tx_on_reg <= 1'b0;
                if (byte_cnt_reg != 4'h0) begin
                    if (!write_cycle_busy && aligned && known_op(opcode_reg, quad)) begin
                        case (opcode_reg)
                            `FPC_OP_QPI_ON: begin
                                if (quad_enable_bit) begin
                                    four_wire_instruction_mode <= 1'b1;
                                end
                            end
                            `FPC_OP_QPI_OFF: four_wire_instruction_mode <= 1'b0;
                            `FPC_OP_GLOCK: lock_reg <= {NBLK{1'b1}};
                            `FPC_OP_GUNLOCK: lock_reg <= {NBLK{1'b0}};
                            `FPC_OP_BLOCK: begin
                                if (has_addr) begin
                                    lock_reg[blk_idx] <= 1'b1;
                                end
                            end
                            `FPC_OP_BUNLOCK: begin
                                if (has_addr) begin
                                    lock_reg[blk_idx] <= 1'b0;
                                end
                            end
                            default: begin
                                if (is_pe && has_addr) begin
                                    op_code <= opcode_reg;
                                    op_addr <= addr_reg;
                                    op_go <= ~prot_hit;
                                    op_blocked <= prot_hit;
                                    op_dropped <= prot_hit;
                                end else if (is_pe) begin
                                    op_dropped <= 1'b1;
                                end
                            end
                        endcase
                    end else if (is_pe) begin
                        // Mid-byte end or busy array: pulse op_dropped, operation not started
                        op_dropped <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// >>> fpc_frontend_chk.sv
/*
 * Port checker for the flash command front end.
 * Assumes binding to fpc_frontend, one core clock and active-low reset.
 */
`timescale 1ns/1ps
`include "fpc_defs.vh"
module fpc_frontend_chk (
    input wire core_clk, // Core clock
    input wire rst_b, // Reset, active low
    input wire chip_sel_b, // Select pin
    input wire [3:0] io_oe, // Pin drive enables
    input wire quad_enable_bit, // Quad allowed
    input wire write_cycle_busy, // Engine busy
    input wire four_wire_instruction_mode, // Four-wire mode
    input wire op_go, // Start pulse
    input wire [7:0] op_code, // Started opcode
    input wire op_blocked, // Protection refusal
    input wire op_dropped, // Discard pulse
    input wire pgm_overrun // Lost program byte
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Outcome pulses are mutually consistent
    a_go_exclusive: assert property (op_go |-> !op_blocked && !op_dropped)
        else $error("start together with refusal");
    a_block_drops: assert property (op_blocked |-> op_dropped)
        else $error("blocked op not discarded");
    // Action only once select has been high long enough to be seen
    a_go_after_cs: assert property (op_go |-> chip_sel_b && $past(chip_sel_b, 3))
        else $error("start before select rose");
    a_go_single: assert property (op_go |=> !op_go)
        else $error("start pulse longer than one cycle");
    a_idle_busy: assert property (op_go |-> !$past(write_cycle_busy))
        else $error("start while engine busy");
    a_go_opcode: assert property (op_go |-> op_code inside {`FPC_OP_PGM, `FPC_OP_SE4K,
        `FPC_OP_BE32K, `FPC_OP_BE64K, `FPC_OP_CE_A, `FPC_OP_CE_B})
        else $error("start with non-write opcode");
    // Four-wire entry only on quad enable; mode changes only between frames
    a_quad_needs_qe: assert property ($rose(four_wire_instruction_mode) |-> $past(quad_enable_bit))
        else $error("four-wire mode without quad enable");
    a_mode_at_end: assert property ($changed(four_wire_instruction_mode) |-> chip_sel_b)
        else $error("mode changed inside a frame");
    // Pins released when deselected; lane count follows the mode
    a_oe_released: assert property (chip_sel_b [*6] |-> io_oe == 4'h0)
        else $error("pins driven while deselected");
    a_oe_width: assert property (io_oe != 4'h0 |->
        io_oe == (four_wire_instruction_mode ? 4'hf : 4'h2))
        else $error("wrong drive lanes");

    c_go: cover property (op_go);
    c_blocked: cover property (op_blocked);
    c_quad: cover property ($rose(four_wire_instruction_mode));
    c_overrun: cover property (pgm_overrun);
endmodule

bind fpc_frontend fpc_frontend_chk chk (.core_clk, .rst_b, .chip_sel_b, .io_oe, .quad_enable_bit,
    .write_cycle_busy, .four_wire_instruction_mode, .op_go, .op_code, .op_blocked, .op_dropped,
    .pgm_overrun);

// >>> fpc_host_model.sv
/*
 * Host controller model: frames instructions on the serial link.
 * Assumes core_clk at 25 MHz; one serial period is eight core cycles.
 */
`timescale 1ns/1ps
module fpc_host_model (
    input wire logic core_clk, // Pacing clock
    input wire logic [3:0] io_out, // Device data out
    output logic chip_sel_b = 1'b1, // Select, active low
    output logic serial_clk = 1'b0, // Serial clock, still between frames
    output logic [3:0] io_in = 4'h5 // Data to device
);
    // Half a serial period, moved on falling core edges
    task automatic half;
        repeat (4) @(negedge core_clk);
    endtask

    // One frame; read bits taken late in the high phase, where they are settled
    task automatic frame(input bit quad, input logic [7:0] b[$], input int cut,
                         input int nrx, output logic [31:0] rx);
        int n;
        logic [7:0] c;
        n = 8 * b.size() - cut;
        rx = 32'h0;
        chip_sel_b = 1'b0;
        for (int i = 0; i < n + nrx; i += (quad ? 4 : 1)) begin
            if (i < n) begin
                c = b[i / 8];
                io_in = quad ? ((i % 8) != 0 ? c[3:0] : c[7:4]) : {~io_in[3:1], c[7 - i % 8]};
            end else begin
                io_in = ~io_in;
            end
            half;
            serial_clk = 1'b1;
            repeat (3) @(negedge core_clk);
            if (i >= n) rx = {rx[30:0], io_out[1]};
            @(negedge core_clk);
            serial_clk = 1'b0;
        end
        half;
        chip_sel_b = 1'b1;
        io_in = ~io_in;
        half;
        half;
    endtask
endmodule

// >>> fpc_frontend_test.sv
/*
 * Self-checking bench for the flash command front end.
 * Assumes fpc_host_model as link partner and the bound port checker.
 */
`timescale 1ns/1ps
`include "fpc_defs.vh"
module fpc_frontend_test;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [6:0] prot_cfg = 7'h40; // Scheme, complement, sector, top, range
    logic qe = 1'b0, busy = 1'b0, pgm_ready = 1'b0;
    logic [7:0] status = 8'h00;
    wire chip_sel_b, serial_clk, mode, op_go, op_blocked, op_dropped;
    wire pgm_valid, pgm_space, pgm_overrun;
    wire [3:0] io_in, io_out, io_oe;
    wire [7:0] op_code, pgm_data;
    wire [23:0] op_addr;
    logic [34:0] exp_q[$];
    int error_cnt = 0;
    int checked = 0;
    // Outcome, sector, top, range bits, opcode, address
    localparam logic [39:0] prot_tbl [14] = '{40'h60_20_000000, 40'h87_20_123000,
        40'h81_d8_3f0000, 40'h61_d8_3e0000, 40'h89_20_00f000, 40'h69_20_010000,
        40'h91_20_3ff000, 40'h71_20_3fe000, 40'h9d_20_007000, 40'h7d_52_008000,
        40'h86_20_200000, 40'h66_52_1f8000, 40'h94_52_3f8000, 40'h74_20_3f7000};

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    // Identity codes are arbitrary values
    fpc_frontend #(.MAKER_CODE(8'ha5), .DEV_CODE8(8'h3c), .DEV_CODE16(16'h7e21)) dut (
        .core_clk, .rst_b, .chip_sel_b, .serial_clk, .io_in, .io_out, .io_oe,
        .protect_scheme_select(prot_cfg[6]), .protect_complement(prot_cfg[5]),
        .sector_granularity_select(prot_cfg[4]), .top_bottom_select(prot_cfg[3]),
        .range_bit_2(prot_cfg[2]), .range_bit_1(prot_cfg[1]), .range_bit_0(prot_cfg[0]),
        .quad_enable_bit(qe), .status_byte(status), .write_cycle_busy(busy),
        .four_wire_instruction_mode(mode), .op_go, .op_code, .op_addr, .op_blocked,
        .op_dropped, .pgm_data, .pgm_valid, .pgm_ready, .pgm_space, .pgm_overrun);
    fpc_host_model host (.core_clk, .io_out, .chip_sel_b, .serial_clk, .io_in);

    task automatic check(input string nm, input logic [34:0] seen, input logic [34:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Erase or program frame; outcome noted before it is sent
    task automatic op(input bit q, input logic [7:0] c, input logic [23:0] a, input int cut,
                      input logic [2:0] e);
        logic [7:0] b[$];
        logic [31:0] r;
        b = {c, a[23:16], a[15:8], a[7:0]};
        exp_q.push_back({e, c, a});
        host.frame(q, b, cut, 0, r);
    endtask

    // Read frame: opcode, filler bytes, then nrx reply bits
    task automatic rd(input bit q, input logic [7:0] c, input int nb, input int nrx,
                      input logic [31:0] e);
        logic [7:0] b[$];
        logic [31:0] r;
        b = {c};
        repeat (nb) b.push_back(8'h00);
        host.frame(q, b, 0, nrx, r);
        check("read reply", r, e);
    endtask

    // Each outcome pulse is paired with the oldest note; none left means a stray pulse
    always @(negedge core_clk) begin
        logic [34:0] e;
        if (rst_b && (op_go || op_blocked || op_dropped)) begin
            e = exp_q.size() != 0 ? exp_q.pop_front() : 35'h0;
            check("op outcome", {op_go, op_blocked, op_dropped}, e[34:32]);
            if (op_go || op_blocked) check("op target", {op_code, op_addr}, e[31:0]);
        end
    end

    initial begin
        logic [7:0] b[$];
        logic [31:0] r;
        logic [23:0] a;
        void'($urandom(91640));
        status = 8'($urandom);
        a = 24'($urandom) & 24'h3ff000;
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        op(1'b0, `FPC_OP_SE4K, a, 0, 3'b011);
        prot_cfg = 7'h00;
        op(1'b0, `FPC_OP_SE4K, a, 0, 3'b100);
        foreach (prot_tbl[i]) begin
            prot_cfg = {2'b01, prot_tbl[i][36:32]};
            op(1'b0, prot_tbl[i][31:24], prot_tbl[i][23:0], 0, prot_tbl[i][39:37]);
        end
        rd(1'b0, `FPC_OP_GUNLOCK, 0, 0, 32'h0);
        prot_cfg = 7'h40;
        op(1'b0, `FPC_OP_SE4K, a, 0, 3'b100);
        prot_cfg = 7'h00;
        op(1'b0, `FPC_OP_SE4K, 24'h001000, 3, 3'b001);
        rd(1'b0, `FPC_OP_JID, 0, 5, 32'h14);
        rd(1'b0, `FPC_OP_JID, 0, 24, 32'ha57e21);
        rd(1'b0, `FPC_OP_MID, 3, 16, 32'ha53c);
        rd(1'b0, `FPC_OP_ID8, 3, 8, 32'h3c);
        busy = 1'b1;
        rd(1'b0, `FPC_OP_RDSR, 0, 16, {16'h0, status, status});
        busy = 1'b0;
        // Four-wire entry refused without quad enable, then taken
        rd(1'b0, `FPC_OP_QPI_ON, 0, 0, 32'h0);
        check("mode", mode, 1'b0);
        qe = 1'b1;
        rd(1'b0, `FPC_OP_QPI_ON, 0, 0, 32'h0);
        check("mode", mode, 1'b1);
        op(1'b1, `FPC_OP_BE64K, 24'h2a0000, 0, 3'b100);
        op(1'b1, `FPC_OP_SE4K, 24'h001000, 4, 3'b001);
        rd(1'b1, `FPC_OP_QPI_OFF, 0, 0, 32'h0);
        check("mode", mode, 1'b0);
        // Seventeen data bytes against a stalled engine: the last is lost
        b = {`FPC_OP_PGM, 8'h00, 8'h01, 8'h00};
        repeat (17) b.push_back(8'($urandom));
        exp_q.push_back({3'b100, `FPC_OP_PGM, 24'h000100});
        host.frame(1'b0, b, 0, 0, r);
        check("overrun", pgm_overrun, 1'b1);
        check("space", pgm_space, 1'b0);
        for (int i = 4; i < 20; i++) begin
            for (int k = 0; k < 20 && pgm_valid !== 1'b1; k++) @(negedge core_clk);
            if (pgm_valid !== 1'b1) begin
                error_cnt++;
                tally_and_finish;
            end else begin
                check("program byte", pgm_data, b[i]);
                pgm_ready = 1'b1;
                @(negedge core_clk);
                pgm_ready = 1'b0;
                @(negedge core_clk);
            end
        end
        check("drained", pgm_valid, 1'b0);
        check("pending ops", exp_q.size(), 0);
        tally_and_finish;
    end
endmodule
